// [hw/lsc_pkg.sv]
// Constants and types for the lockstep compare checker
//--------------------------------------------------------------------
//--------------------------------------------------------------------
package lsc_pkg;
   // Compare segments
   localparam int LSC_NSEG   = 3;
   localparam int LSC_SEG_AL = 0;
   localparam int LSC_SEG_AH = 1;
   localparam int LSC_SEG_DB = 2;
   // Register byte offsets
   localparam logic [7:0] LSC_OFS_CTRL = 8'h00;
   localparam logic [7:0] LSC_OFS_STAT = 8'h04;
   localparam logic [7:0] LSC_OFS_MASK = 8'h08;
   localparam logic [7:0] LSC_OFS_INFO = 8'h0c;
   // Control field positions
   localparam int LSC_CTRL_FLAG = 7;
   localparam int LSC_CTRL_FDB  = 2;
   localparam int LSC_CTRL_FORCE_ADDR_HIGH_MISMATCH = 1;
   localparam int LSC_CTRL_FORCE_ADDR_LOW_MISMATCH = 0;
   // Status and mask layout: bits 2..0 segment failures, bit 3 forced
   localparam int LSC_IRQ_W     = 4;
   localparam int LSC_IRQ_FORCE = 3;
   // Reset values
   localparam logic [2:0]           LSC_FORCE_RST = 3'h0;
   localparam logic [LSC_IRQ_W-1:0] LSC_IRQ_RST   = 4'h0;
   // Internal reset request length, in clock cycles
   localparam int LSC_RST_HOLD_CYC = 4;

   typedef enum logic {
      LSC_IDLE = 1'b0,
      LSC_HOLD = 1'b1
   } lsc_state_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } lsc_bus_s;
endpackage : lsc_pkg

// [hw/lsc_checker.sv]
// Lockstep compare checker with fault pin and APB registers
`timescale 1ns/1ns
module lsc_checker
   import lsc_pkg::*;
#(
   parameter int RST_HOLD_CYC = LSC_RST_HOLD_CYC
) (
   // Clock and power-on reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Internal bus, primary and duplicate CPU outputs
   input  wire lsc_bus_s    prim_bus,
   input  wire lsc_bus_s    dup_bus,
   input  wire logic [7:0]  sys_rdata,
   // Read data path toward the duplicate CPU
   output logic [7:0]       dup_rdata,
   output logic             dup_rdata_oe,
   // Reset request, fault pin and interrupt
   output logic             int_rst_req,
   output logic             fault_out_n,
   output logic             irq
);

   //-----------------------------------------------------------------
   // Parameter checks
   //-----------------------------------------------------------------
   // The request length check below needs the bound to stay within 1000
   if (RST_HOLD_CYC < 1 || RST_HOLD_CYC > 999) begin : g_bad_hold
      $error("RST_HOLD_CYC must lie in 1..999");
   end

   localparam int HOLD_BOUND = RST_HOLD_CYC + 1;
   localparam int CW = $clog2(RST_HOLD_CYC + 1);

   //-----------------------------------------------------------------
   // State
   //-----------------------------------------------------------------
   lsc_state_e           state_reg, state_next;
   logic [CW-1:0]        hold_reg, hold_next;
   logic                 fault_reg, fault_next;
   logic [2:0]           force_reg, force_next;
   logic [2:0]           pend_reg, pend_next;
   logic [LSC_IRQ_W-1:0] stat_reg, stat_next;
   logic [LSC_IRQ_W-1:0] mask_reg, mask_next;
   logic [31:0]          rdata_reg, rdata_next;

   //-----------------------------------------------------------------
   // APB decode
   //-----------------------------------------------------------------
   wire logic wr_acc   = psel & penable & pwrite;
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = (paddr == LSC_OFS_CTRL);
   wire logic hit_stat = (paddr == LSC_OFS_STAT);
   wire logic hit_mask = (paddr == LSC_OFS_MASK);
   wire logic hit_info = (paddr == LSC_OFS_INFO);
   wire logic mapped   = hit_ctrl | hit_stat | hit_mask | hit_info;
   wire logic wr_ctrl  = wr_acc & hit_ctrl;
   wire logic wr_stat  = wr_acc & hit_stat;
   wire logic wr_mask  = wr_acc & hit_mask;
   // A force write is any control write carrying a 1 in a force bit
   wire logic wr_force = wr_ctrl & (|pwdata[2:0]);
   wire logic clr_flag = wr_ctrl & ~pwdata[LSC_CTRL_FLAG];

   // Zero wait states; unmapped offsets answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   //-----------------------------------------------------------------
   // Read data path for the duplicate CPU
   //-----------------------------------------------------------------
   // Reads feed the system data to the duplicate; buffers off on writes
   assign dup_rdata_oe = prim_bus.valid & ~prim_bus.write;
   assign dup_rdata    = sys_rdata;

   //-----------------------------------------------------------------
   // Segment compare
   //-----------------------------------------------------------------
   // Both CPUs share pclk, so each bus cycle is compared as it happens.
   // Compares are ignored while the reset request runs, as both cores
   // sit in reset then and their buses carry no meaning.
   wire logic cmp_on = prim_bus.valid & (state_reg == LSC_IDLE);
   logic [7:0] prim_seg [LSC_NSEG];
   logic [7:0] dup_seg  [LSC_NSEG];
   logic [LSC_NSEG-1:0] seg_en;
   logic [LSC_NSEG-1:0] seg_fail;

   assign prim_seg[LSC_SEG_AL] = prim_bus.addr[7:0];
   assign prim_seg[LSC_SEG_AH] = prim_bus.addr[15:8];
   assign prim_seg[LSC_SEG_DB] = prim_bus.wdata;
   assign dup_seg[LSC_SEG_AL]  = dup_bus.addr[7:0];
   assign dup_seg[LSC_SEG_AH]  = dup_bus.addr[15:8];
   assign dup_seg[LSC_SEG_DB]  = dup_bus.wdata;
   assign seg_en[LSC_SEG_AL]   = cmp_on;
   assign seg_en[LSC_SEG_AH]   = cmp_on;
   // Data is only meaningful to compare on write cycles
   assign seg_en[LSC_SEG_DB]   = cmp_on & prim_bus.write;

   // One comparator per segment, each with its own force input
   for (genvar i = 0; i < LSC_NSEG; i++) begin : g_seg
      wire logic real_miss = seg_en[i] & (prim_seg[i] != dup_seg[i]);
      wire logic forced    = (state_reg == LSC_IDLE) & pend_reg[i];
      assign seg_fail[i] = real_miss | forced;
   end

   wire logic any_fail = |seg_fail;
   wire logic was_forced = (state_reg == LSC_IDLE) & (|pend_reg);

   //-----------------------------------------------------------------
   // Reset request sequencer
   //-----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      hold_next  = hold_reg;
      case (state_reg)
         LSC_IDLE: begin
            if (any_fail) begin
               state_next = LSC_HOLD;
               hold_next  = CW'(RST_HOLD_CYC - 1);
            end
         end
         LSC_HOLD: begin
            if (hold_reg == '0) begin
               state_next = LSC_IDLE;
            end else begin
               hold_next = hold_reg - 1'b1;
            end
         end
         default: state_next = LSC_IDLE;
      endcase
   end

   // Request is a plain level, merged by the reset controller like others
   assign int_rst_req = (state_reg == LSC_HOLD);

   //-----------------------------------------------------------------
   // Fault flag and pin
   //-----------------------------------------------------------------
   // Set wins over a clear landing in the same cycle; only power-on
   // reset reaches this flop, so internal resets never disturb it.
   assign fault_next = any_fail | (fault_reg & ~clr_flag);
   assign fault_out_n = ~fault_reg;

   //-----------------------------------------------------------------
   // Control, force and interrupt registers
   //-----------------------------------------------------------------
   // Force bits double as the record of which segment failed
   assign force_next = wr_ctrl ? (pwdata[2:0] | seg_fail)
                               : (force_reg | seg_fail);
   // A force is a one-shot: consumed when it fails its comparator
   assign pend_next = (wr_force ? pwdata[2:0] : 3'h0)
                    | (was_forced ? 3'h0 : pend_reg);
   assign stat_next = (stat_reg & ~(wr_stat ? pwdata[LSC_IRQ_W-1:0]
                                             : LSC_IRQ_RST))
                    | {was_forced, seg_fail};
   assign mask_next = wr_mask ? pwdata[LSC_IRQ_W-1:0] : mask_reg;
   assign irq       = |(stat_reg & mask_reg);

   // Read mux, captured in the setup phase; flag bit always reads 0
   always_comb begin
      rdata_next = rdata_reg;
      if (rd_setup) begin
         if (hit_ctrl) begin
            rdata_next = {29'h0, force_reg};
         end else if (hit_stat) begin
            rdata_next = {28'h0, stat_reg};
         end else if (hit_mask) begin
            rdata_next = {28'h0, mask_reg};
         end else if (hit_info) begin
            rdata_next = {30'h0, int_rst_req, fault_reg};
         end else begin
            rdata_next = 32'h0;
         end
      end
   end
   assign prdata = rdata_reg;

   //-----------------------------------------------------------------
   // Flip-flops, power-on reset only
   //-----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= LSC_IDLE;
         hold_reg  <= '0;
      end else begin
         state_reg <= state_next;
         hold_reg  <= hold_next;
      end
   end

   // Fault storage: only power-on or a control write of 0 to bit 7 clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_reg <= LSC_FORCE_RST;
         pend_reg  <= LSC_FORCE_RST;
         stat_reg  <= LSC_IRQ_RST;
         mask_reg  <= LSC_IRQ_RST;
         rdata_reg <= 32'h0;
      end else begin
         force_reg <= force_next;
         pend_reg  <= pend_next;
         stat_reg  <= stat_next;
         mask_reg  <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   //-----------------------------------------------------------------
   // Assertions
   //-----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_fail_sets_all;
      any_fail |=> int_rst_req && !fault_out_n;
   endproperty
   a_fail_sets_all: assert property (p_fail_sets_all)
      else $error("fail did not raise request and fault together");

   property p_fault_holds;
      !fault_out_n && !clr_flag |=> !fault_out_n;
   endproperty
   a_fault_holds: assert property (p_fault_holds)
      else $error("fault pin released without a clear");

   property p_fault_clear;
      clr_flag && !any_fail |=> fault_out_n;
   endproperty
   a_fault_clear: assert property (p_fault_clear)
      else $error("writing 0 to bit 7 did not release fault pin");

   property p_fault_only_on_fail;
      fault_out_n && !any_fail |=> fault_out_n;
   endproperty
   a_fault_only_on_fail: assert property (p_fault_only_on_fail)
      else $error("fault pin fell without a mismatch");

   property p_req_ends;
      $rose(int_rst_req) |-> ##[1:HOLD_BOUND] !int_rst_req;
   endproperty
   a_req_ends: assert property (p_req_ends)
      else $error("reset request did not end in time");

   property p_force_resets;
      wr_force && state_reg == LSC_IDLE && !any_fail |=> ##1 int_rst_req;
   endproperty
   a_force_resets: assert property (p_force_resets)
      else $error("force write was not followed by reset request");

   property p_flag_reads0;
      psel && penable && !pwrite && hit_ctrl |-> !prdata[LSC_CTRL_FLAG];
   endproperty
   a_flag_reads0: assert property (p_flag_reads0)
      else $error("fault flag bit read back as 1");

   property p_seg_recorded;
      |seg_fail |=> (force_reg & $past(seg_fail)) == $past(seg_fail);
   endproperty
   a_seg_recorded: assert property (p_seg_recorded)
      else $error("failing segment not recorded in its force bit");

   property p_read_no_data;
      cmp_on && !prim_bus.write && pend_reg == 3'h0
         && prim_bus.addr == dup_bus.addr |=> !int_rst_req;
   endproperty
   a_read_no_data: assert property (p_read_no_data)
      else $error("read cycle data compare caused a reset");

   property p_write_buffers;
      prim_bus.valid && prim_bus.write |-> !dup_rdata_oe;
   endproperty
   a_write_buffers: assert property (p_write_buffers)
      else $error("duplicate data buffers driven on a write");

   property p_addr_compare;
      cmp_on && prim_bus.addr[15:8] != dup_bus.addr[15:8]
         |=> int_rst_req && force_reg[LSC_CTRL_FORCE_ADDR_HIGH_MISMATCH];
   endproperty
   a_addr_compare: assert property (p_addr_compare)
      else $error("high address mismatch missed");

   // Every failing segment must also leave its sticky status bit
   property p_stat_records;
      |seg_fail |=> (stat_reg[LSC_NSEG-1:0] & $past(seg_fail))
         == $past(seg_fail);
   endproperty
   a_stat_records: assert property (p_stat_records)
      else $error("failing segment not recorded in status");

endmodule : lsc_checker

// [dv/lsc_cpu_model.sv]
// Behavioural primary CPU and system bus feeding the lockstep checker
`timescale 1ns/1ns
module lsc_cpu_model
   import lsc_pkg::*;
(
   // Clock
   input  wire logic       pclk,
   // Cycle request and fault injection from the bench
   input  wire lsc_bus_s   req,
   input  wire logic [2:0] bad,
   input  wire logic [7:0] rd_val,
   // Bus toward the checker
   output lsc_bus_s        prim_bus,
   output lsc_bus_s        dup_bus,
   output logic [7:0]      sys_rdata
);
   lsc_bus_s last_reg = '0;

   // Remember the last cycle so an idle bus never shows a stale copy
   always @(posedge pclk) begin
      if (req.valid) begin
         last_reg <= req;
      end
   end

   // Both cores start from initialised, identical state, so the
   // duplicate mirrors the primary unless a scenario injects a fault
   assign prim_bus  = req.valid ? req
                    : lsc_bus_s'{1'b0, 1'b0, ~last_reg.addr, ~last_reg.wdata};
   assign dup_bus   = '{prim_bus.valid, prim_bus.write,
                        prim_bus.addr ^ {{8{bad[1]}}, {8{bad[0]}}},
                        prim_bus.wdata ^ {8{bad[2]}}};
   assign sys_rdata = (req.valid && !req.write) ? rd_val : ~last_reg.wdata;
endmodule : lsc_cpu_model

// [dv/lockstep_cpu_compare_bench.sv]
// Self-checking bench for the lockstep compare checker
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s expected %0h seen %0h", nm, e, g); \
   end end
module lockstep_cpu_compare_bench;
   import lsc_pkg::*;
   localparam int HOLD = 4;
   //------------------------------------------------------------------
   // Signals and instances
   //------------------------------------------------------------------
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, dup_rdata_oe, int_rst_req;
   logic        fault_out_n, irq;
   logic [7:0]  sys_rdata, dup_rdata, rd_val = 8'h00;
   logic [2:0]  bad = 3'h0;
   lsc_bus_s    req = '0, prim_bus, dup_bus;
   logic [31:0] seed = 32'h9fcc61b2;
   int          bad_count = 0, n_checks = 0, exp_ctrl, exp_stat;
   logic        model_fault = 1'b0;

   always #10 pclk = ~pclk;

   lsc_checker #(.RST_HOLD_CYC(HOLD)) lsc_checker_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prim_bus(prim_bus), .dup_bus(dup_bus),
      .sys_rdata(sys_rdata), .dup_rdata(dup_rdata),
      .dup_rdata_oe(dup_rdata_oe), .int_rst_req(int_rst_req),
      .fault_out_n(fault_out_n), .irq(irq));
   lsc_cpu_model lsc_cpu_model_i (.pclk(pclk), .req(req), .bad(bad),
      .rd_val(rd_val), .prim_bus(prim_bus), .dup_bus(dup_bus),
      .sys_rdata(sys_rdata));

   //------------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         bad_count++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input int e);
      apb(1'b0, a, 32'h0);
      `CHK("register", e, rd)
   endtask : rd_chk

   // One machine cycle with optional injected segment faults
   task automatic cyc(input logic w, input logic [2:0] b, input logic f);
      logic [31:0] t;
      t = xs();
      @(posedge pclk);
      req <= '{1'b1, w, t[15:0], t[23:16]};
      bad <= b;
      rd_val <= t[31:24];
      #1;
      `CHK("rdata_oe", ~w, dup_rdata_oe)
      if (!w) `CHK("dup_rdata", t[31:24], dup_rdata)
      @(posedge pclk);
      req.valid <= 1'b0;
      bad <= 3'h0;
      #1;
      if (f) model_fault = 1'b1;
      `CHK("rst_req", f, int_rst_req)
      `CHK("fault_n", ~model_fault, fault_out_n)
   endtask : cyc

   // The request must stand exactly the chosen number of cycles
   task automatic hold_chk();
      int n;
      for (n = 0; n < 2000 && int_rst_req === 1'b1; n++) begin
         @(posedge pclk);
         #1;
      end
      `CHK("hold", HOLD, n)
      if (n >= 2000) final_report();
   endtask : hold_chk

   task automatic clear_all();
      apb(1'b1, LSC_OFS_STAT, 32'hf);
      apb(1'b1, LSC_OFS_CTRL, 32'h0);
      model_fault = 1'b0;
      #1;
      `CHK("fault_clr", 1'b1, fault_out_n)
      `CHK("irq_clr", 1'b0, irq)
   endtask : clear_all

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   initial begin
      #2000000;
      bad_count++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(LSC_OFS_CTRL, 0);
      rd_chk(LSC_OFS_STAT, 0);
      rd_chk(LSC_OFS_MASK, 0);
      rd_chk(LSC_OFS_INFO, 0);
      rd_chk(8'h10, 0);
      `CHK("slverr", 1'b1, er)
      `CHK("fault_n", 1'b1, fault_out_n)
      $display("test reset done");
      for (int k = 0; k < 12; k++) cyc(1'(xs()), 3'h0, 1'b0);
      cyc(1'b0, 3'h4, 1'b0);
      $display("test clean traffic done");
      apb(1'b1, LSC_OFS_MASK, 32'hf);
      for (int s = 0; s < LSC_NSEG; s++) begin
         cyc(1'b1, 3'(1 << s), 1'b1);
         hold_chk();
         `CHK("irq", 1'b1, irq)
         cyc(1'b1, 3'h0, 1'b0);
         rd_chk(LSC_OFS_CTRL, 1 << s);
         rd_chk(LSC_OFS_STAT, 1 << s);
         rd_chk(LSC_OFS_INFO, 1);
         // Writing 1 to the flag bit must leave the pin low
         apb(1'b1, LSC_OFS_CTRL, 32'h80);
         #1;
         `CHK("flag_keep", 1'b0, fault_out_n)
         clear_all();
      end
      $display("test real mismatch done");
      for (int s = 0; s < LSC_NSEG; s++) begin
         apb(1'b1, LSC_OFS_CTRL, 1 << s);
         @(posedge pclk);
         req <= '{1'b1, 1'b1, 16'h1234, 8'h5a};
         #1;
         for (int n = 0; n < 20 && int_rst_req !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
         end
         `CHK("force_rst", 1'b1, int_rst_req)
         if (int_rst_req !== 1'b1) final_report();
         `CHK("force_fault", 1'b0, fault_out_n)
         hold_chk();
         @(posedge pclk);
         req.valid <= 1'b0;
         exp_stat = (1 << s) | (1 << LSC_IRQ_FORCE);
         rd_chk(LSC_OFS_STAT, exp_stat);
         apb(1'b1, LSC_OFS_MASK, 32'h0);
         #1;
         `CHK("irq_masked", 1'b0, irq)
         apb(1'b1, LSC_OFS_MASK, 32'hf);
         #1;
         `CHK("irq_unmasked", 1'b1, irq)
         clear_all();
      end
      $display("test forced mismatch done");
      cyc(1'b0, 3'h1, 1'b1);
      hold_chk();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      model_fault = 1'b0;
      #1;
      `CHK("por_fault", 1'b1, fault_out_n)
      exp_ctrl = 0;
      rd_chk(LSC_OFS_CTRL, exp_ctrl);
      $display("test power-on release done");
      final_report();
   end
endmodule : lockstep_cpu_compare_bench
